// ### hdl/spi_master_usart_consts.vh
// register map, field positions and reset values of the master spi port
`ifndef SPI_MASTER_USART_CONSTS_VH
`define SPI_MASTER_USART_CONSTS_VH
`define ADDR_STATUS      3'h0
`define ADDR_ENABLE      3'h1
`define ADDR_FORMAT      3'h2
`define ADDR_DATA        3'h3
`define ADDR_BAUD_LO     3'h4
`define ADDR_BAUD_HI     3'h5
`define ADDR_GLOBAL_IRQ  3'h6
`define ADDR_PORT_CTRL   3'h7
`define ST_RXC           7
`define ST_TXC           6
`define ST_UDRE          5
`define EN_RXCIE         7
`define EN_TXCIE         6
`define EN_BUFFER_EMPTY_IRQ_ENABLE_BIT         5
`define EN_RXEN          4
`define EN_TXEN          3
`define FMT_MODE_HI      7
`define FMT_MODE_LO      6
`define FMT_ORDER        2
`define FMT_PHASE        1
`define FMT_POLARITY     0
`define MODE_MSPI        2'h3
`define ENABLE_WMASK     8'hf8
`define FORMAT_WMASK     8'hc7
`define ENABLE_RESET     8'h00
`define FORMAT_RESET     8'h00
`define BAUD_RESET       12'h000
`define BYTE_ZERO        8'h00
`define FRAME_BITS       4'h8
`define RX_DEPTH         2'h2
`endif

// ### hdl/spi_master_usart.v
// master-only spi port of a serial unit, with its register file
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`include "spi_master_usart_consts.vh"

// Behaviour
// - master spi mode runs only when mode-select field equals binary 11
// - receive-complete flag high while receive buffer holds unread data
// - disabling receiver flushes receive buffer and clears receive-complete
// - transmit-complete sets when frame done and transmit buffer empty
// - transmit-complete clears on interrupt service or writing one to it
// - buffer-empty flag set when buffer can accept byte; one after reset
// - interrupt only if source enable, global flag and source flag set
// - receiver enable turns receiver on and takes the serial-input pin
// - transmitter enable turns transmitter on and takes serial-output pin
// - disabled transmitter finishes shift and buffer before releasing pin
// - order bit one sends least significant bit first, else most
// - phase bit picks sampling on leading or trailing clock edge
// - polarity bit sets clock idle level; four standard spi modes
// - order, phase, polarity accepted in the write selecting master mode
// - transmitter double buffered; queued byte follows without a gap
// - receiver holds one extra buffered byte while next arrives
// - master only: drives data out and clock, samples data in, no select
// - no write-collision flag and no double-speed bit
// - frames are eight bits; receiver and transmitter share bit order
// - data write starts a transfer that sends and receives one byte
// - on receive overflow the newest byte is dropped, older ones kept
// - frame-error, overrun and parity-error bits always read zero
module spi_master_usart #(
  parameter BAUD_W = 12
) (
  // clock and reset
  input  wire       core_clk,
  input  wire       reset_n,
  // register port
  input  wire [2:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWrite,
  input  wire       regRead,
  output reg  [7:0] regRdData,
  // interrupt service acknowledges
  input  wire       txcIrqAck,
  // interrupt requests
  output wire       rxcIrq,
  output wire       txcIrq,
  output wire       udreIrq,
  // serial pins
  input  wire       serialIn,
  output reg        serialOut,
  output wire       serialOutEn_n,
  output reg        transferClk,
  output wire       transferClkEn_n,
  output wire       serialInOwned
);

  // register state
  reg  [7:0]        enableCtrl_ff;
  reg  [7:0]        modeFormat_ff;
  reg  [BAUD_W-1:0] baud_ff;
  reg               globalIrq_ff;
  reg               clkPinDir_ff;
  reg               txc_ff;
  reg  [7:0]        txBuf_ff;
  reg               txBufFull_ff;
  reg  [7:0]        txShift_ff;
  reg  [7:0]        rxShift_ff;
  reg               busy_ff;
  reg  [3:0]        bitCnt_ff;
  reg               secondHalf_ff;
  reg  [BAUD_W-1:0] divCnt_ff;
  reg  [7:0]        rxBuf0_ff;
  reg  [7:0]        rxBuf1_ff;
  reg  [1:0]        rxCount_ff;
  reg               txOwn_ff;
  reg               inSync1_ff;
  reg               inSync2_ff;

  wire mspiOn = modeFormat_ff[`FMT_MODE_HI:`FMT_MODE_LO] == `MODE_MSPI;
  wire rxEn     = enableCtrl_ff[`EN_RXEN];
  wire txEn     = enableCtrl_ff[`EN_TXEN];
  wire lsbFirst = modeFormat_ff[`FMT_ORDER];
  wire cpha     = modeFormat_ff[`FMT_PHASE];
  wire cpol     = modeFormat_ff[`FMT_POLARITY];
  wire rxc      = rxCount_ff != 2'h0;
  wire udre     = !txBufFull_ff;
  wire wrData   = regWrite && regAddr == `ADDR_DATA;
  wire rdData   = regRead && regAddr == `ADDR_DATA;
  wire halfTick = busy_ff && divCnt_ff == {BAUD_W{1'b0}};
  wire lastEdge = halfTick && secondHalf_ff && bitCnt_ff == `FRAME_BITS - 4'h1;
  wire startNow = mspiOn && (txEn || txOwn_ff) && txBufFull_ff
                  && (!busy_ff || lastEdge);
  wire [7:0] rxNext = lsbFirst ? {inSync2_ff, rxShift_ff[7:1]}
                               : {rxShift_ff[6:0], inSync2_ff};

  // edge roles inside a bit: sample edge shifts in, setup edge shifts out
  wire       sampleEdge = secondHalf_ff == cpha;
  wire       txOutBit   = lsbFirst ? txShift_ff[0] : txShift_ff[7];
  wire [7:0] txShifted  = lsbFirst ? {1'b0, txShift_ff[7:1]}
                                   : {txShift_ff[6:0], 1'b0};

  // shifter image at frame start; phase zero has its first bit out already
  reg  [7:0] txPreload;
  always @*
  begin
    txPreload = txBuf_ff;
    case ({cpha, lsbFirst})
      2'b00:
        txPreload = {txBuf_ff[6:0], 1'b0};
      2'b01:
        txPreload = {1'b0, txBuf_ff[7:1]};
      default:
        txPreload = txBuf_ff;
    endcase
  end

  // interrupt gating
  assign rxcIrq  = enableCtrl_ff[`EN_RXCIE] && globalIrq_ff && rxc;
  assign txcIrq  = enableCtrl_ff[`EN_TXCIE] && globalIrq_ff && txc_ff;
  assign udreIrq = enableCtrl_ff[`EN_BUFFER_EMPTY_IRQ_ENABLE_BIT] && globalIrq_ff && udre;

  // pin ownership
  assign serialOutEn_n   = !(txOwn_ff && mspiOn);
  assign transferClkEn_n = !(clkPinDir_ff && mspiOn);
  assign serialInOwned   = rxEn && mspiOn;

  // serial input synchroniser
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      inSync1_ff <= 1'b0;
      inSync2_ff <= 1'b0;
    end
    else
    begin
      inSync1_ff <= serialIn;
      inSync2_ff <= inSync1_ff;
    end
  end

  // control registers
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      enableCtrl_ff <= `ENABLE_RESET;
      modeFormat_ff <= `FORMAT_RESET;
      baud_ff       <= `BAUD_RESET;
      globalIrq_ff  <= 1'b0;
      clkPinDir_ff  <= 1'b0;
    end
    else if (regWrite)
    begin
      case (regAddr)
        `ADDR_ENABLE:
          enableCtrl_ff <= regWrData & `ENABLE_WMASK;
        `ADDR_FORMAT:
          modeFormat_ff <= regWrData & `FORMAT_WMASK;
        `ADDR_BAUD_LO:
          baud_ff[7:0] <= regWrData;
        `ADDR_BAUD_HI:
          baud_ff[BAUD_W-1:8] <= regWrData[BAUD_W-9:0];
        `ADDR_GLOBAL_IRQ:
          globalIrq_ff <= regWrData[0];
        `ADDR_PORT_CTRL:
          clkPinDir_ff <= regWrData[0];
        default:
          ;
      endcase
    end
  end

  // transmit buffer, complete flag and pin hold
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txBuf_ff     <= `BYTE_ZERO;
      txBufFull_ff <= 1'b0;
      txc_ff       <= 1'b0;
      txOwn_ff     <= 1'b0;
    end
    else
    begin
      if (wrData && !txBufFull_ff && mspiOn && txEn)
      begin
        txBuf_ff     <= regWrData;
        txBufFull_ff <= 1'b1;
      end
      else if (startNow)
        txBufFull_ff <= 1'b0;
      if (lastEdge && !txBufFull_ff)
        txc_ff <= 1'b1;
      else if (txcIrqAck || (regWrite && regAddr == `ADDR_STATUS
               && regWrData[`ST_TXC]))
        txc_ff <= 1'b0;
      if (txEn)
        txOwn_ff <= 1'b1;
      else if (!busy_ff && !txBufFull_ff)
        txOwn_ff <= 1'b0;
    end
  end

  // shift engine
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy_ff       <= 1'b0;
      bitCnt_ff     <= 4'h0;
      secondHalf_ff <= 1'b0;
      divCnt_ff     <= {BAUD_W{1'b0}};
      txShift_ff    <= `BYTE_ZERO;
      rxShift_ff    <= `BYTE_ZERO;
      serialOut     <= 1'b1;
      transferClk   <= 1'b0;
    end
    else if (startNow)
    begin
      busy_ff       <= 1'b1;
      bitCnt_ff     <= 4'h0;
      secondHalf_ff <= 1'b0;
      divCnt_ff     <= baud_ff;
      transferClk   <= cpol;
      txShift_ff    <= txPreload;
      if (!cpha)
        serialOut <= lsbFirst ? txBuf_ff[0] : txBuf_ff[7];
    end
    else if (!busy_ff)
    begin
      transferClk <= cpol;
      serialOut   <= 1'b1;
    end
    else if (halfTick)
    begin
      divCnt_ff     <= baud_ff;
      secondHalf_ff <= !secondHalf_ff;
      transferClk   <= !transferClk;
      if (sampleEdge)
        rxShift_ff <= rxNext;
      else
      begin
        serialOut  <= txOutBit;
        txShift_ff <= txShifted;
      end
      if (secondHalf_ff)
      begin
        bitCnt_ff <= bitCnt_ff + 4'h1;
        if (bitCnt_ff == `FRAME_BITS - 4'h1)
          busy_ff <= 1'b0;
      end
    end
    else
      divCnt_ff <= divCnt_ff - {{(BAUD_W-1){1'b0}}, 1'b1};
  end

  // receive buffer, two levels
  wire rxPush = lastEdge && rxEn;
  wire rxRoom = rxCount_ff != `RX_DEPTH;
  wire rxPop  = rdData && rxc;
  wire [7:0] rxByte = cpha ? rxNext : rxShift_ff;
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxBuf0_ff  <= `BYTE_ZERO;
      rxBuf1_ff  <= `BYTE_ZERO;
      rxCount_ff <= 2'h0;
    end
    else if (!rxEn || !mspiOn)
      rxCount_ff <= 2'h0;
    else
    begin
      case ({rxPush && rxRoom, rxPop})
        2'b10:
        begin
          if (rxCount_ff == 2'h0)
            rxBuf0_ff <= rxByte;
          else
            rxBuf1_ff <= rxByte;
          rxCount_ff <= rxCount_ff + 2'h1;
        end
        2'b01:
        begin
          rxBuf0_ff  <= rxBuf1_ff;
          rxCount_ff <= rxCount_ff - 2'h1;
        end
        2'b11:
        begin
          if (rxCount_ff == 2'h1)
            rxBuf0_ff <= rxByte;
          else
          begin
            rxBuf0_ff <= rxBuf1_ff;
            rxBuf1_ff <= rxByte;
          end
        end
        default:
          ;
      endcase
    end
  end

  // read data, one cycle after the strobe
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      regRdData <= `BYTE_ZERO;
    else if (regRead)
    begin
      case (regAddr)
        `ADDR_STATUS:
          regRdData <= {rxc, txc_ff, udre, 5'h00};
        `ADDR_ENABLE:
          regRdData <= enableCtrl_ff;
        `ADDR_FORMAT:
          regRdData <= modeFormat_ff;
        `ADDR_DATA:
          regRdData <= rxc ? rxBuf0_ff : `BYTE_ZERO;
        `ADDR_BAUD_LO:
          regRdData <= baud_ff[7:0];
        `ADDR_BAUD_HI:
          regRdData <= {{(16-BAUD_W){1'b0}}, baud_ff[BAUD_W-1:8]};
        `ADDR_GLOBAL_IRQ:
          regRdData <= {7'h00, globalIrq_ff};
        `ADDR_PORT_CTRL:
          regRdData <= {7'h00, clkPinDir_ff};
        default:
          regRdData <= `BYTE_ZERO;
      endcase
    end
  end

endmodule

// ### test/spi_master_usart_properties.sv
// concurrent checks on the master spi port pins
`timescale 1ns/1ns
`include "spi_master_usart_consts.vh"
module spi_master_usart_properties #(
  parameter BAUD_W = 12
) (
  // clock and reset
  input wire       core_clk,
  input wire       reset_n,
  // register port
  input wire [2:0] regAddr,
  input wire [7:0] regWrData,
  input wire       regWrite,
  input wire       regRead,
  input wire [7:0] regRdData,
  // interrupts
  input wire       txcIrqAck,
  input wire       rxcIrq,
  input wire       txcIrq,
  input wire       udreIrq,
  // serial pins
  input wire       serialIn,
  input wire       serialOut,
  input wire       serialOutEn_n,
  input wire       transferClk,
  input wire       transferClkEn_n,
  input wire       serialInOwned
);
  reg  [7:0]  ctl_ff;
  reg  [1:0]  mode_ff;
  reg         gie_ff;
  reg  [15:0] baud_ff;
  reg  [15:0] gap_ff;
  reg         clk_ff;
  wire        mspi = mode_ff == `MODE_MSPI;
  // shadow of control registers, cycles since last clock edge
  always @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      ctl_ff <= 8'h00;
      mode_ff <= 2'h0;
      gie_ff <= 1'b0;
      baud_ff <= 16'h0000;
      gap_ff <= 16'h0000;
      clk_ff <= 1'b0;
    end
    else
    begin
      if (regWrite && regAddr == `ADDR_ENABLE)
        ctl_ff <= regWrData;
      if (regWrite && regAddr == `ADDR_FORMAT)
        mode_ff <= regWrData[7:6];
      if (regWrite && regAddr == `ADDR_GLOBAL_IRQ)
        gie_ff <= regWrData[0];
      if (regWrite && regAddr == `ADDR_BAUD_LO)
        baud_ff[7:0] <= regWrData;
      if (regWrite && regAddr == `ADDR_BAUD_HI)
        baud_ff[15:8] <= {4'h0, regWrData[3:0]};
      clk_ff <= transferClk;
      gap_ff <= (clk_ff != transferClk) ? 16'h0000 : gap_ff + 16'h0001;
    end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence rxOff;
    !ctl_ff[`EN_RXEN] ##1 !ctl_ff[`EN_RXEN];
  endsequence
  sequence statusRead;
    regRead && regAddr == `ADDR_STATUS;
  endsequence
  chk_rxc_gate: assert property (
    rxcIrq |-> gie_ff && ctl_ff[`EN_RXCIE])
    else $error("rx irq without enables");
  chk_status_zero: assert property (
    statusRead |=> regRdData[4:0] == 5'h00)
    else $error("status low bits not zero");
  chk_txc_wclear: assert property (
    regWrite && regAddr == `ADDR_STATUS && regWrData[`ST_TXC] |=> !txcIrq)
    else $error("tx complete not cleared");
  chk_tx_pin: assert property (
    ctl_ff[`EN_TXEN] && mspi |-> ##[0:1] !serialOutEn_n)
    else $error("output pin not taken");
  chk_rx_pin: assert property (
    ctl_ff[`EN_RXEN] && mspi |-> ##[0:1] serialInOwned)
    else $error("input pin not taken");
  chk_mode_gate: assert property (
    !mspi |-> ##[0:1] serialOutEn_n && !serialInOwned)
    else $error("port active outside spi mode");
  chk_rx_flush: assert property (
    rxOff |-> !rxcIrq && !serialInOwned)
    else $error("receiver off but data kept");
  chk_bit_period: assert property (
    clk_ff != transferClk |-> gap_ff >= baud_ff)
    else $error("clock half period too short");
endmodule

// ### test/spi_slave_model.sv
// behavioural spi slave on the far side of the link
`timescale 1ns/1ns
module spi_slave_model #(
  parameter REPLY = 8'hc5
) (
  // link pins
  input  wire       sck,
  input  wire       mosi,
  output wire       miso,
  // setup and results
  input  wire       cpol,
  input  wire       cpha,
  input  wire       lsbFirst,
  output reg  [7:0] rxByte,
  output reg  [7:0] frames
);
  reg [7:0] sh = REPLY;
  reg [3:0] cnt = 4'h0;
  reg       inFrame = 1'b0;
  initial
  begin
    rxByte = 8'h00;
    frames = 8'h00;
  end
  assign miso = lsbFirst ? sh[0] : sh[7];
  // sample and setup edges per mode, eight bits a frame
  always @(sck)
  begin
    if (sck != cpol)
      inFrame = 1'b1;
    if (inFrame)
    begin
      if (sck ^ cpol ^ cpha)
      begin
        rxByte = lsbFirst ? {mosi, rxByte[7:1]} : {rxByte[6:0], mosi};
        cnt = cnt + 4'h1;
      end
      else if (cnt != 4'h0 && cnt != 4'h8)
        sh = lsbFirst ? sh >> 1 : sh << 1;
      if (cnt == 4'h8 && sck == cpol)
      begin
        cnt = 4'h0;
        inFrame = 1'b0;
        frames = frames + 8'h01;
        sh = REPLY ^ frames;
      end
    end
  end
endmodule

// ### test/testbench.sv
// self-checking bench for the master spi port
`timescale 1ns/1ns
`include "spi_master_usart_consts.vh"
module testbench;
  reg        core_clk = 1'b0;
  reg        reset_n = 1'b0;
  reg  [2:0] regAddr = 3'h0;
  reg  [7:0] regWrData = 8'h00;
  reg        regWrite = 1'b0;
  reg        regRead = 1'b0;
  reg        txcIrqAck = 1'b0;
  reg  [2:0] cfg = 3'h0;
  reg  [7:0] got;
  wire [7:0] regRdData, rxByte, frames;
  wire       rxcIrq, txcIrq, udreIrq, serialIn, serialOut;
  wire       serialOutEn_n, transferClk, transferClkEn_n, serialInOwned;
  integer    failCount = 0;
  integer    totalChecks = 0;
  integer    cycles = 0;
  integer    i;
  integer    n;
  spi_master_usart DUT (.*);
  spi_slave_model slave (.sck(transferClk), .mosi(serialOut),
    .miso(serialIn), .cpol(cfg[0]), .cpha(cfg[1]), .lsbFirst(cfg[2]),
    .rxByte(rxByte), .frames(frames));
  always #5 core_clk = ~core_clk;
  task endOfTest;
  begin
    if (failCount == 0 && totalChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 10000)
    begin
      failCount = failCount + 1;
      endOfTest;
    end
  end
  task cmp(input [7:0] e, input [7:0] a);
  begin
    totalChecks = totalChecks + 1;
    if (a !== e)
    begin
      failCount = failCount + 1;
      $display("mismatch at %0t: got %h want %h", $time, a, e);
    end
  end
  endtask
  task wr(input [2:0] a, input [7:0] d);
  begin
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    @(posedge core_clk);
  end
  endtask
  task chk(input [2:0] a, input [7:0] e);
  begin
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(posedge core_clk);
    cmp(e, regRdData);
  end
  endtask
  task waitFrames(input [7:0] f);
  begin
    n = 0;
    while (frames !== f && n < 3000)
    begin
      @(posedge core_clk);
      n = n + 1;
    end
    cmp(f, frames);
    repeat (16) @(posedge core_clk);
  end
  endtask
  initial
  begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    chk(`ADDR_STATUS, 8'h20);
    chk(`ADDR_FORMAT, 8'h00);
    wr(`ADDR_BAUD_LO, 8'h07);
    wr(`ADDR_PORT_CTRL, 8'h01);
    for (i = 0; i < 8; i = i + 1)
    begin
      cfg <= i[2:0];
      wr(`ADDR_FORMAT, {5'h18, i[2:0]});
      wr(`ADDR_ENABLE, 8'h18);
      wr(`ADDR_DATA, 8'h1e ^ i[7:0]);
      cmp(8'h00, {6'h00, serialOutEn_n, transferClkEn_n});
      waitFrames(i[7:0] + 8'h01);
      cmp(8'h1e ^ i[7:0], rxByte);
      chk(`ADDR_DATA, 8'hc5 ^ i[7:0]);
    end
    wr(`ADDR_STATUS, 8'h40);
    wr(`ADDR_DATA, 8'ha1);
    wr(`ADDR_DATA, 8'hb2);
    chk(`ADDR_STATUS, 8'h00);
    waitFrames(8'h09);
    wr(`ADDR_DATA, 8'hc3);
    waitFrames(8'h0b);
    chk(`ADDR_STATUS, 8'he0);
    cmp(8'hc3, rxByte);
    chk(`ADDR_DATA, 8'hcd);
    chk(`ADDR_DATA, 8'hcc);
    chk(`ADDR_STATUS, 8'h60);
    wr(`ADDR_STATUS, 8'h40);
    chk(`ADDR_STATUS, 8'h20);
    wr(`ADDR_ENABLE, 8'hf8);
    wr(`ADDR_GLOBAL_IRQ, 8'h01);
    cmp(8'h01, {7'h00, udreIrq});
    wr(`ADDR_ENABLE, 8'hd8);
    cmp(8'h00, {7'h00, udreIrq});
    wr(`ADDR_DATA, 8'h3c);
    waitFrames(8'h0c);
    cmp(8'h03, {6'h00, txcIrq, rxcIrq});
    txcIrqAck <= 1'b1;
    @(posedge core_clk);
    txcIrqAck <= 1'b0;
    @(posedge core_clk);
    cmp(8'h01, {6'h00, txcIrq, rxcIrq});
    wr(`ADDR_GLOBAL_IRQ, 8'h00);
    cmp(8'h00, {7'h00, rxcIrq});
    wr(`ADDR_GLOBAL_IRQ, 8'h01);
    wr(`ADDR_ENABLE, 8'hc8);
    chk(`ADDR_STATUS, 8'h20);
    cmp(8'h00, {7'h00, serialInOwned});
    wr(`ADDR_DATA, 8'h81);
    wr(`ADDR_ENABLE, 8'h00);
    cmp(8'h00, {7'h00, serialOutEn_n});
    waitFrames(8'h0d);
    cmp(8'h01, {7'h00, serialOutEn_n});
    cfg <= 3'h0;
    wr(`ADDR_ENABLE, 8'h18);
    wr(`ADDR_FORMAT, 8'h40);
    wr(`ADDR_DATA, 8'h55);
    repeat (300) @(posedge core_clk);
    cmp(8'h0d, frames);
    cmp(8'h01, {7'h00, serialOutEn_n});
    endOfTest;
  end
endmodule
bind spi_master_usart spi_master_usart_properties #(.BAUD_W(BAUD_W)) chk (.*);
